// ===== dv/dgc_host_model.sv
// Purpose: host bus and cascaded master facing the arbiter
// Assumes: master sits on one cascade channel
// Notes:   slow mode delays the hold acknowledge
`timescale 1ns/1ps
module dgc_host_model #(
  parameter [2:0] CH = 3'h5
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Host hold handshake
  input  wire       slow,
  input  wire       hold_req,
  output reg        host_hold_ack,
  // Cascaded master
  input  wire       want_bus,
  input  wire       ack_valid,
  input  wire [2:0] encoded_ack,
  output wire       casc_req
);
  reg  [2:0] dly_r;
  reg        had_r;
  reg        lost_r;
  wire       grant = ack_valid && encoded_ack == CH;
  assign casc_req = want_bus && !lost_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dly_r         <= 3'h0;
      host_hold_ack <= 1'b0;
      had_r         <= 1'b0;
      lost_r        <= 1'b0;
    end else begin
      dly_r         <= {dly_r[1:0], hold_req};
      host_hold_ack <= hold_req && (!slow || dly_r[2]);
      had_r         <= grant;
      lost_r        <= (lost_r || (had_r && !grant)) && want_bus;
    end
  end
endmodule

// ===== dv/dgc_monitor.sv
// Purpose: port checker for the DMA group arbiter
// Assumes: one clock, clk_en held high
// Notes:   bounds follow the arbiter latencies
`timescale 1ns/1ps
module dgc_monitor (
  // Clock and reset
  input wire       clk_sys,
  input wire       rst,
  // Bus and arbiter
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  input wire       refresh_req,
  input wire       host_hold_ack,
  input wire       xfer_done,
  input wire       hold_req,
  input wire       refresh_go,
  input wire       dma_go,
  input wire       ack_valid,
  input wire [2:0] encoded_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ready_always_a: assert property (pready)
    else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  grant_code_a: assert property (ack_valid |-> encoded_ack != 3'h4)
    else $error("grant without channel code");
  idle_code_a: assert property (!ack_valid |-> encoded_ack == 3'h4)
    else $error("code shown without grant");
  refresh_alone_a: assert property (refresh_go |-> !dma_go && !ack_valid)
    else $error("refresh shares the bus");
  bus_owned_a: assert property ((dma_go || ack_valid || refresh_go) |-> host_hold_ack)
    else $error("bus used without hold ack");
  refresh_asks_a: assert property (refresh_req && !hold_req && !host_hold_ack
    |-> ##[1:3] hold_req)
    else $error("refresh did not request bus");
  xfer_first_a: assert property (dma_go && !xfer_done |=> !refresh_go)
    else $error("refresh cut a transfer");
  cover property ($rose(refresh_go));
  cover property ($rose(ack_valid));
  cover property (dma_go && refresh_req);
endmodule
bind dgc_group_ctl dgc_monitor dgc_monitor_inst (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .refresh_req(refresh_req), .host_hold_ack(host_hold_ack), .xfer_done(xfer_done),
  .hold_req(hold_req), .refresh_go(refresh_go), .dma_go(dma_go),
  .ack_valid(ack_valid), .encoded_ack(encoded_ack));

// ===== dv/test_dma_group_control_and_refresh_arbiter.sv
// Purpose: bench for the DMA group arbiter
// Assumes: host model answers hold; clk_en dropped once to test freezing
// Notes:   flags sampled at falling edges
`timescale 1ns/1ps
module test_dma_group_control_and_refresh_arbiter;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [7:0]  hw = 0, cexp = 0, eop = 0, cset = 0, cld = 0;
  logic        rreq = 0, xd = 0, xl = 0, rdone = 0, want = 0, slow = 0, ce = 1;
  wire         pready, pslverr, hold, hack, rgo, dgo, av, creq;
  wire  [31:0] prdata, pw;
  wire  [2:0]  ach, eack;
  wire  [15:0] gcmd;
  wire  [47:0] m1, m2;
  wire  [7:0]  chen;
  int          fail_count = 0, n_checks = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  dgc_group_ctl dgc_group_ctl_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .channel_request(hw | {2'b00, creq, 5'h00}), .refresh_req(rreq), .hold_req(hold),
    .host_hold_ack(hack), .xfer_done(xd), .xfer_last(xl), .count_expired(cexp),
    .end_of_process_in(eop), .chain_irq_set(cset), .chain_loaded(cld),
    .refresh_done(rdone), .refresh_go(rgo), .dma_go(dgo), .active_chan(ach),
    .encoded_ack(eack), .ack_valid(av), .group_cmd_flat(gcmd), .mode_one_flat(m1),
    .mode_two_flat(m2), .path_width_flat(pw), .chain_enable(chen));
  dgc_host_model dgc_host_model_inst (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .hold_req(hold), .host_hold_ack(hack), .want_bus(want), .ack_valid(av),
    .encoded_ack(eack), .casc_req(creq));
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // Let the edge's register updates settle before callers compare
    @(negedge clk_sys);
  endtask
  task automatic rc(logic [11:0] a, logic [7:0] e);
    apb(0, a, 0);
    chk("prdata", q[7:0], e);
  endtask
  function automatic logic sg(int s);
    case (s)
      0: return hold;
      1: return dgo;
      2: return rgo;
      default: return av;
    endcase
  endfunction
  task automatic ws(int s, logic v);
    for (int i = 0; i < 40 && sg(s) !== v; i++) @(negedge clk_sys);
    chk("flag", sg(s), v);
  endtask
  task automatic t_reset;
    chk("gcmd", gcmd, 16'h3180);
    chk("mode1", m1, 0);
    chk("mode2", m2, 0);
    chk("width_chain", {pw, chen}, 0);
    rc(12'h018, 8'h0f);
    rc(12'h010, 8'h00);
    rc(12'h01c, 8'h00);
  endtask
  task automatic t_regs;
    apb(1, 12'h000, 32'h02);
    apb(1, 12'h044, 32'h02);
    chk("gcmd", gcmd, 16'h1580);
    @(posedge clk_sys) ce <= 0;
    apb(1, 12'h000, 32'h01);
    @(posedge clk_sys) ce <= 1;
    chk("frozen", gcmd, 16'h1580);
    apb(1, 12'h008, 32'hb5);
    chk("mode1", m1[11:6], 6'h2d);
    apb(1, 12'h04c, 32'h0e);
    chk("mode2", m2[41:36], 6'h03);
    apb(1, 12'h020, 32'h27);
    chk("width", pw[15:12], 4'h9);
    apb(1, 12'h064, 32'h06);
    chk("chain", chen, 8'h40);
    apb(1, 12'h014, 32'h00);
    rc(12'h018, 8'h0e);
    rc(12'h058, 8'h0f);
    apb(1, 12'h018, 32'h05);
    rc(12'h018, 8'h05);
    apb(1, 12'h028, 32'h00);
    rc(12'h018, 8'h00);
    apb(0, 12'h030, 0);
    chk("unmapped", {err, q}, 33'h100000000);
  endtask
  task automatic t_dma;
    @(posedge clk_sys) rreq <= 1;
    ws(2, 1);
    @(posedge clk_sys) rdone <= 1;
    rreq <= 0;
    @(posedge clk_sys) rdone <= 0;
    apb(1, 12'h018, 32'h0f);
    apb(1, 12'h010, 32'h06);
    rc(12'h010, 8'h04);
    ws(1, 1);
    chk("chan", ach, 3'h2);
    @(posedge clk_sys) rreq <= 1;
    repeat (3) @(negedge clk_sys);
    chk("dma_held", {dgo, rgo}, 2'b10);
    @(posedge clk_sys) xd <= 1;
    @(posedge clk_sys) xd <= 0;
    ws(2, 1);
    @(posedge clk_sys) rdone <= 1;
    rreq <= 0;
    @(posedge clk_sys) rdone <= 0;
    ws(1, 1);
    chk("chan", ach, 3'h2);
    @(posedge clk_sys) rreq <= 1;
    xd <= 1;
    xl <= 1;
    cexp <= 8'h04;
    @(posedge clk_sys) xd <= 0;
    xl <= 0;
    cexp <= 0;
    ws(2, 1);
    chk("hold", hold, 1);
    @(posedge clk_sys) rdone <= 1;
    rreq <= 0;
    @(posedge clk_sys) rdone <= 0;
    ws(0, 0);
    rc(12'h010, 8'h00);
    rc(12'h01c, 8'h04);
    rc(12'h01c, 8'h00);
  endtask
  task automatic t_stat;
    @(posedge clk_sys) eop <= 8'h08;
    hw <= 8'h02;
    cset <= 8'h02;
    @(posedge clk_sys) eop <= 0;
    cset <= 0;
    rc(12'h01c, 8'h28);
    rc(12'h024, 8'h02);
    @(posedge clk_sys) hw <= 0;
    cld <= 8'h02;
    @(posedge clk_sys) cld <= 0;
    rc(12'h01c, 8'h00);
    rc(12'h024, 8'h00);
  endtask
  task automatic t_casc;
    slow <= 1;
    apb(1, 12'h048, 32'hc1);
    apb(1, 12'h054, 32'h01);
    @(posedge clk_sys) want <= 1;
    ws(3, 1);
    chk("code", eack, 3'h5);
    @(posedge clk_sys) rreq <= 1;
    ws(3, 0);
    chk("early_refresh", rgo, 0);
    ws(2, 1);
    @(posedge clk_sys) want <= 0;
    @(posedge clk_sys) want <= 1;
    @(posedge clk_sys) rdone <= 1;
    rreq <= 0;
    @(posedge clk_sys) rdone <= 0;
    ws(3, 1);
    chk("code", eack, 3'h5);
    @(posedge clk_sys) rreq <= 1;
    ws(3, 0);
    ws(2, 1);
    @(posedge clk_sys) want <= 0;
    rdone <= 1;
    rreq <= 0;
    @(posedge clk_sys) rdone <= 0;
    ws(0, 0);
    chk("ack", av, 0);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    t_reset();
    t_regs();
    t_dma();
    t_stat();
    t_casc();
    results();
  end
endmodule

// ===== hdl/dgc_group_ctl.v
// Purpose: control/status registers of two 4-channel DMA groups and the
//          bus arbiter that lets refresh pre-empt DMA and cascade work
// Assumes: APB slave, zero wait states; datapath reports transfer ends
// Notes:   channel address/count datapaths live elsewhere
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dgc_regs.vh"

// Behaviour
// [RULE1] Refresh outranks every channel and may pre-empt running work
// [RULE2] Refresh during DMA waits for transfer end then resumes same channel
// [RULE3] Refresh after a final transfer runs before bus returns to host
// [RULE4] Refresh during cascade drops ack, waits for request to fall
// [RULE5] Cascaded master releases bus by dropping its request
// [RULE6] Cascade resumes only if request returned before refresh ended
// [RULE7] Host hold acknowledge reaches this block alone
// [RULE8] Forty-four host registers, twenty-four of them channel registers
// [RULE9] Each four-channel group has its own control registers
// [RULE10] Command one: group enable, priority mode; reset clears it
// [RULE11] Command two: sampling, lowest channel; reset async, 3 and 7
// [RULE12] Mode one per channel; reset verify, no autoinit, increment, demand
// [RULE13] Mode two per channel; reset no hold, increment, memory, single flow
// [RULE14] Software request bits set/cleared by channel, read per group
// [RULE15] Software request clears on terminal count or end of process
// [RULE16] Software requests ignore masks and arbitrate equally
// [RULE17] Mask bits: single set/clear port and four-bit read/write port
// [RULE18] Clear-mask command clears group masks; reset masks all
// [RULE19] Status terminal-count bits set on expiry, cleared by status read
// [RULE20] Status request bits follow the hardware request inputs
// [RULE21] Bus-size register per channel; reset gives 8-bit paths
// [RULE22] Chaining enable per channel; read gives chain interrupt status
// [RULE23] Cascade grant is encoded_ack carrying the channel code
module dgc_group_ctl (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Requests and bus handshake
  input  wire [7:0]  channel_request,
  input  wire        refresh_req,
  output reg         hold_req,
  input  wire        host_hold_ack,
  // Datapath handshake
  input  wire        xfer_done,
  input  wire        xfer_last,
  input  wire [7:0]  count_expired,
  input  wire [7:0]  end_of_process_in,
  input  wire [7:0]  chain_irq_set,
  input  wire [7:0]  chain_loaded,
  input  wire        refresh_done,
  // Grant outputs
  output reg         refresh_go,
  output reg         dma_go,
  output reg  [2:0]  active_chan,
  output reg  [2:0]  encoded_ack,
  output reg         ack_valid,
  // Channel configuration seen by the datapath
  output wire [15:0] group_cmd_flat,
  output wire [47:0] mode_one_flat,
  output wire [47:0] mode_two_flat,
  output wire [31:0] path_width_flat,
  output wire [7:0]  chain_enable
);

  localparam ST_IDLE = 3'd0;
  localparam ST_HOLD = 3'd1;
  localparam ST_DMA  = 3'd2;
  localparam ST_CASC = 3'd3;
  localparam ST_CDRP = 3'd4;
  localparam ST_REFR = 3'd5;
  localparam ST_REL  = 3'd6;

  reg [7:0] cmd1_r [0:1];
  reg [7:0] cmd2_r [0:1];
  reg [5:0] mode1_r [0:7];
  reg [5:0] mode2_r [0:7];
  reg [3:0] bsize_r [0:7];
  reg [7:0] sreq_r;
  reg [7:0] mask_r;
  reg [7:0] tc_r;
  reg [7:0] chain_en_r;
  reg [7:0] chain_irq_r;
  reg [1:0] rot_r [0:1];
  reg [2:0] state_r;
  reg       resume_r;
  reg       casc_back_r;
  reg       casc_int_r;

  integer i;

  // Highest-priority pending channel of one group, given lowest channel
  function [2:0] dgc_pick;
    input [3:0] req;
    input [1:0] low;
    reg   [1:0] k;
    integer     j;
    begin
      dgc_pick = 3'b000;
      k = low;
      for (j = 0; j < 4; j = j + 1) begin
        k = k + 2'd1;
        if (req[k] && !dgc_pick[2])
          dgc_pick = {1'b1, k};
      end
    end
  endfunction

  wire        apb_acc = psel && penable;
  wire        wr_en   = apb_acc && pwrite && clk_en;
  wire        rd_en   = apb_acc && !pwrite && clk_en;
  wire        grp     = (paddr[11:6] == 6'd1);
  wire        grp_ok  = (paddr[11:7] == 5'd0);
  wire [11:0] off     = {6'd0, paddr[5:0]};
  wire [2:0]  wch     = {grp, pwdata[1:0]};
  wire        wset    = pwdata[`DGC_SEL_SET_BIT];
  // [RULE8] Register map decode
  wire        mapped  = grp_ok && (off <= `DGC_OFF_CLRMSK) && (off[1:0] == 2'b00);

  assign pready  = 1'b1;
  assign pslverr = apb_acc && !mapped;

  // [RULE16] Software requests bypass mask
  wire [7:0] pend = sreq_r | (channel_request & ~mask_r &
                    {{4{~cmd1_r[1][`DGC_CMD1_DIS_BIT]}}, {4{~cmd1_r[0][`DGC_CMD1_DIS_BIT]}}});
  wire [1:0] low0 = cmd1_r[0][`DGC_CMD1_ROT_BIT] ? rot_r[0] : cmd2_r[0][2:1];
  wire [1:0] low1 = cmd1_r[1][`DGC_CMD1_ROT_BIT] ? rot_r[1] : cmd2_r[1][2:1];
  wire [2:0] p0   = dgc_pick(pend[3:0], low0);
  wire [2:0] p1   = dgc_pick(pend[7:4], low1);
  wire       any  = p0[2] | p1[2];
  wire [2:0] win  = p0[2] ? {1'b0, p0[1:0]} : {1'b1, p1[1:0]};
  // Channel 4 cannot cascade: its code is the idle code
  wire       is_casc = (mode1_r[win][5:4] == `DGC_MODE_CASCADE) && (win != 3'd4);
  wire [7:0] end_ev  = count_expired | end_of_process_in;

  // Register file
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 2; i = i + 1) begin
        // [RULE10] Command one reset
        cmd1_r[i] <= `DGC_CMD1_RST;
        // [RULE11] Command two reset
        cmd2_r[i] <= `DGC_CMD2_RST;
        rot_r[i]  <= 2'd3;
      end
      for (i = 0; i < 8; i = i + 1) begin
        // [RULE12] Mode one reset
        mode1_r[i] <= `DGC_MODE1_RST;
        // [RULE13] Mode two reset
        mode2_r[i] <= `DGC_MODE2_RST;
        // [RULE21] Bus size reset
        bsize_r[i] <= `DGC_BSIZE_RST;
      end
      sreq_r      <= 8'h00;
      // [RULE18] Reset masks all
      mask_r      <= {2{`DGC_MASK_RST}};
      tc_r        <= 8'h00;
      chain_en_r  <= 8'h00;
      chain_irq_r <= 8'h00;
    end else if (clk_en) begin
      // [RULE9] Per-group command writes
      if (wr_en && grp_ok && off == `DGC_OFF_CMD1)
        cmd1_r[grp] <= pwdata[7:0];
      if (wr_en && grp_ok && off == `DGC_OFF_CMD2)
        cmd2_r[grp] <= pwdata[7:0];
      if (wr_en && grp_ok && off == `DGC_OFF_MODE1)
        mode1_r[wch] <= pwdata[7:2];
      if (wr_en && grp_ok && off == `DGC_OFF_MODE2)
        mode2_r[wch] <= pwdata[7:2];
      if (wr_en && grp_ok && off == `DGC_OFF_BSIZE)
        bsize_r[wch] <= pwdata[5:2];
      // Rotation makes the channel just granted the lowest
      if (dma_go && xfer_done) begin
        if (active_chan[2])
          rot_r[1] <= active_chan[1:0];
        else
          rot_r[0] <= active_chan[1:0];
      end
      for (i = 0; i < 8; i = i + 1) begin
        // [RULE14] Software request set/clear
        if (wr_en && grp_ok && off == `DGC_OFF_SREQ && wch == i)
          sreq_r[i] <= wset;
        // [RULE15] End of buffer clears request
        if (end_ev[i])
          sreq_r[i] <= 1'b0;
        // [RULE17] Single-channel mask port
        if (wr_en && grp_ok && off == `DGC_OFF_MSK1 && wch == i)
          mask_r[i] <= wset;
        if (wr_en && grp_ok && off == `DGC_OFF_MSKA && grp == i[2])
          mask_r[i] <= pwdata[i[1:0]];
        // [RULE18] Clear-mask command
        if (wr_en && grp_ok && off == `DGC_OFF_CLRMSK && grp == i[2])
          mask_r[i] <= 1'b0;
        // [RULE19] Read clears, event wins
        if (rd_en && grp_ok && off == `DGC_OFF_STAT && grp == i[2])
          tc_r[i] <= 1'b0;
        if (end_ev[i])
          tc_r[i] <= 1'b1;
        // [RULE22] Chaining enable and status
        if (wr_en && grp_ok && off == `DGC_OFF_CHAIN && wch == i)
          chain_en_r[i] <= wset;
        if (chain_loaded[i])
          chain_irq_r[i] <= 1'b0;
        if (chain_irq_set[i])
          chain_irq_r[i] <= 1'b1;
      end
    end
  end

  // Read data is registered during the setup cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      case (mapped ? off : 12'hfff)
        `DGC_OFF_SREQ:  prdata <= {28'h0, grp ? sreq_r[7:4] : sreq_r[3:0]};
        `DGC_OFF_MSKA:  prdata <= {28'h0, grp ? mask_r[7:4] : mask_r[3:0]};
        // [RULE20] Live request bits in status
        `DGC_OFF_STAT:  prdata <= {24'h0,
                                   grp ? channel_request[7:4] : channel_request[3:0],
                                   grp ? tc_r[7:4] : tc_r[3:0]};
        `DGC_OFF_CHAIN: prdata <= {28'h0, grp ? chain_irq_r[7:4] : chain_irq_r[3:0]};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Bus arbiter
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      hold_req    <= 1'b0;
      refresh_go  <= 1'b0;
      dma_go      <= 1'b0;
      active_chan <= 3'd0;
      encoded_ack <= 3'd4;
      ack_valid   <= 1'b0;
      resume_r    <= 1'b0;
      casc_back_r <= 1'b0;
      casc_int_r  <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          if (refresh_req || any) begin
            hold_req <= 1'b1;
            state_r  <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (host_hold_ack) begin
            // [RULE1] Refresh first
            if (refresh_req) begin
              refresh_go <= 1'b1;
              state_r    <= ST_REFR;
            end else if (resume_r) begin
              resume_r <= 1'b0;
              dma_go   <= 1'b1;
              state_r  <= ST_DMA;
            end else if (any) begin
              active_chan <= win;
              if (is_casc) begin
                // [RULE23] Grant by channel code
                encoded_ack <= win;
                ack_valid   <= 1'b1;
                state_r     <= ST_CASC;
              end else begin
                dma_go  <= 1'b1;
                state_r <= ST_DMA;
              end
            end else begin
              hold_req <= 1'b0;
              state_r  <= ST_REL;
            end
          end
        end
        ST_DMA: begin
          if (xfer_done) begin
            // [RULE2] Pre-empt between transfers
            if (refresh_req) begin
              dma_go     <= 1'b0;
              // [RULE3] Final transfer still refreshes first
              resume_r   <= !xfer_last;
              refresh_go <= 1'b1;
              state_r    <= ST_REFR;
            end else if (xfer_last) begin
              dma_go   <= 1'b0;
              hold_req <= 1'b0;
              state_r  <= ST_REL;
            end
          end
        end
        ST_CASC: begin
          if (!channel_request[active_chan] || !host_hold_ack) begin
            encoded_ack <= 3'd4;
            ack_valid   <= 1'b0;
            hold_req    <= 1'b0;
            state_r     <= ST_REL;
          end else if (refresh_req) begin
            // [RULE4] Withdraw the grant first
            encoded_ack <= 3'd4;
            ack_valid   <= 1'b0;
            casc_int_r  <= 1'b1;
            state_r     <= ST_CDRP;
          end
        end
        ST_CDRP: begin
          // [RULE5] Master signals release by dropping request
          if (!channel_request[active_chan]) begin
            refresh_go  <= 1'b1;
            casc_back_r <= 1'b0;
            state_r     <= ST_REFR;
          end
        end
        ST_REFR: begin
          // Only a master pushed off for this refresh may win the bus back
          if (casc_int_r && channel_request[active_chan])
            casc_back_r <= 1'b1;
          if (refresh_done) begin
            refresh_go  <= 1'b0;
            casc_int_r  <= 1'b0;
            casc_back_r <= 1'b0;
            // [RULE6] Return to cascade only if request came back
            if (casc_int_r && (casc_back_r || channel_request[active_chan])) begin
              encoded_ack <= active_chan;
              ack_valid   <= 1'b1;
              state_r     <= ST_CASC;
            end else if (resume_r) begin
              resume_r <= 1'b0;
              dma_go   <= 1'b1;
              state_r  <= ST_DMA;
            end else begin
              hold_req <= 1'b0;
              state_r  <= ST_REL;
            end
          end
        end
        ST_REL: begin
          // [RULE7] Wait for host's acknowledge to drop
          if (!host_hold_ack)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_flat
      assign mode_one_flat[g*6 +: 6]   = mode1_r[g];
      assign mode_two_flat[g*6 +: 6]   = mode2_r[g];
      assign path_width_flat[g*4 +: 4] = bsize_r[g];
    end
  endgenerate

  assign group_cmd_flat = {cmd1_r[1][1:0], cmd2_r[1][2:0], cmd1_r[0][1:0], cmd2_r[0][2:0],
                           6'h00};
  assign chain_enable   = chain_en_r;

endmodule

// ===== hdl/dgc_regs.vh
// Purpose: constants for the DMA group control and refresh arbiter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   field layouts are local encodings
`ifndef DGC_REGS_VH
`define DGC_REGS_VH
// Register byte offsets, group 0; group 1 adds DGC_GRP_STRIDE
`define DGC_OFF_CMD1      12'h000
`define DGC_OFF_CMD2      12'h004
`define DGC_OFF_MODE1     12'h008
`define DGC_OFF_MODE2     12'h00c
`define DGC_OFF_SREQ      12'h010
`define DGC_OFF_MSK1      12'h014
`define DGC_OFF_MSKA      12'h018
`define DGC_OFF_STAT      12'h01c
`define DGC_OFF_BSIZE     12'h020
`define DGC_OFF_CHAIN     12'h024
`define DGC_OFF_CLRMSK    12'h028
`define DGC_GRP_STRIDE    12'h040
// Single-channel write layout: [1:0] channel, [2] set/enable
`define DGC_SEL_SET_BIT   2
// Command one: [0] group disable, [1] rotating priority
`define DGC_CMD1_DIS_BIT  0
`define DGC_CMD1_ROT_BIT  1
`define DGC_CMD1_RST      8'h00
// Command two: [0] sync sampling, [2:1] lowest fixed-priority channel
`define DGC_CMD2_RST      8'h06
// Mode one: [1:0] type (00 verify), [2] autoinit, [3] decrement, [5:4] mode
// mode 00 demand, 01 single, 10 block, 11 cascade; data sits in [7:2]
`define DGC_MODE1_RST     6'h00
`define DGC_MODE_CASCADE  2'b11
// Mode two [7:2]: thold, rdec, rhold, tio, rio, two_cycle (0 = single flow)
`define DGC_MODE2_RST     6'h00
// Bus size [5:2]: target[1:0], requester[3:2]; 00 = 8 bit
`define DGC_BSIZE_RST     4'h0
`define DGC_MASK_RST      4'hf
`endif
